// ==== sie_pkg.sv ====
// sie_pkg.sv: constants shared by the subtract execution block
// assumes: compiled before sie_data_ram and sie_core
package sie_pkg;

    // ************************************************************
    // bus and memory geometry
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RAM_AW = 12;
    localparam int RAM_DW = 8;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_ACC = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_BANK_POINTER = 8'h0c;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h10;
    localparam logic [7:0] OFS_MEM_DATA = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // ************************************************************
    // flag bit positions in the flags register
    // ************************************************************
    localparam int FLG_CARRY = 0;
    localparam int FLG_NIBBLE_CARRY = 1;
    localparam int FLG_ZERO = 2;
    localparam int FLG_SIGNED_RANGE = 3;
    localparam int FLG_NEGATIVE = 4;

    // status register bit positions
    localparam int STS_BUSY = 0;
    localparam int STS_ILLEGAL = 1;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] RST_INSTR = 16'h0000;
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [4:0] RST_FLAGS = 5'h00;
    localparam logic [3:0] RST_BANK = 4'h0;
    localparam logic [11:0] RST_MEM_ADDR = 12'h000;

    // ************************************************************
    // opcodes and access bank halves
    // ************************************************************
    localparam logic [7:0] OP_LITERAL = 8'h08;
    localparam logic [5:0] OP_REGISTER = 6'h17;
    localparam logic [3:0] ACCESS_BANK_LO = 4'h0;
    localparam logic [3:0] ACCESS_BANK_HI = 4'hf;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // quarter-phase sequencer, one-hot
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_DECODE = 5'h02,
        S_READ = 5'h04,
        S_PROCESS = 5'h08,
        S_WRITE = 5'h10
    } sie_phase_t;

endpackage : sie_pkg

// ==== sie_data_ram.sv ====
// sie_data_ram.sv: banked data memory, one port, registered read
// assumes: the caller never writes and reads one address expecting new data
`timescale 1ns/1ns
module sie_data_ram
    import sie_pkg::*;
#(
    parameter int AW = RAM_AW,
    parameter int DW = RAM_DW
)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [AW-1:0] addr,
    input wire logic we,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // ************************************************************
    // storage
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
    end

    // read data leaves through a register; old data on a same-cycle write
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= mem[addr];
        end
    end

endmodule : sie_data_ram

// ==== sie_core.sv ====
// sie_core.sv: subtract execution core behind an AXI4-Lite slave
// assumes: a single AXI4-Lite master on mclk; one write and one read open
//
// Notes on behaviour
// RQ1: literal opcode subtracts accumulator from low byte
// RQ2: literal result goes to accumulator, flags updated
// RQ3: literal op takes one four-quarter cycle
// RQ4: register opcode computes register minus accumulator
// RQ5: destination bit zero writes the accumulator only
// RQ6: destination bit one writes the register only
// RQ7: bank bit zero selects the access bank
// RQ8: bank bit one uses the bank pointer
// RQ9: register op takes one four-quarter cycle
// RQ10: carry means no borrow; zero only on zero
// RQ11: borrow stores difference, clears carry; negative copies result bit 7, not the borrow
// RQ12: signed overflow and low-nibble no-borrow flags
`timescale 1ns/1ns
module sie_core
    import sie_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    typedef struct packed {
        sie_phase_t phase;
        logic [15:0] instr;
        logic isLit;
        logic destReg;
        logic illegal;
        logic [7:0] acc;
        logic [4:0] flags;
        logic [4:0] pend;
        logic [3:0] bankPointerRegister;
        logic [11:0] memAddr;
        logic [11:0] target;
        logic [7:0] opA;
        logic [7:0] result;
        logic awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [DATA_W-1:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rPend;
        logic [ADDR_W-1:0] arAddr;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } sie_state_t;

    sie_state_t st;
    sie_state_t next_st;

    logic busy;
    logic wrFire;
    logic literalMinusAccumulator;
    logic registerMinusAccumulator;
    logic [7:0] minuend;
    logic [8:0] diff9;
    logic [4:0] nib5;
    logic [11:0] ramAddr;
    logic ramWe;
    logic [7:0] ramWdata;
    logic [7:0] ramRdata;
    logic [32:0] wrView;
    logic [32:0] rdView;
    logic [31:0] wrMerged;

    // ************************************************************
    // register view: {hit, data} for one offset
    // ************************************************************
    function automatic logic [32:0] sie_view(input logic [7:0] a);
        logic [32:0] v;
        v = {1'b1, 32'h00000000};
        case (a)
            OFS_INSTR: v[15:0] = st.instr;
            OFS_ACC: v[7:0] = st.acc;
            OFS_FLAGS: v[4:0] = st.flags;
            OFS_BANK_POINTER: v[3:0] = st.bankPointerRegister;
            OFS_MEM_ADDR: v[11:0] = st.memAddr;
            OFS_MEM_DATA: v[7:0] = ramRdata;
            OFS_STATUS:
            begin
                v[STS_BUSY] = busy;
                v[STS_ILLEGAL] = st.illegal;
            end
            default: v[32] = 1'b0;
        endcase
        return v;
    endfunction : sie_view

    // ************************************************************
    // decode and arithmetic
    // ************************************************************
    assign busy = (st.phase != S_IDLE);
    assign literalMinusAccumulator = (st.instr[15:8] == OP_LITERAL);
    assign registerMinusAccumulator = (st.instr[15:10] == OP_REGISTER);
    assign minuend = st.isLit ? st.opA : ramRdata;
    // adding the inverted subtrahend plus one: the carry out is "no borrow"
    assign diff9 = {1'b0, minuend} + {1'b0, ~st.acc} + 9'h001; // [RQ4]
    assign nib5 = {1'b0, minuend[3:0]} + {1'b0, ~st.acc[3:0]} + 5'h01;

    // ************************************************************
    // bus handshakes
    // ************************************************************
    assign awready = !st.awHeld && !st.bvalid;
    assign wready = !st.wHeld && !st.bvalid;
    // writes wait while an instruction runs; memory port belongs to it
    assign wrFire = st.awHeld && st.wHeld && !st.bvalid && !busy;
    assign arready = !st.rPend && !st.rvalid && !busy && !wrFire;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;

    always_comb
    begin
        wrView = sie_view(st.awAddr);
        rdView = sie_view(st.arAddr);
        for (int i = 0; i < 4; i++)
        begin
            wrMerged[8*i +: 8] = st.wStrb[i] ? st.wData[8*i +: 8]
                                             : wrView[8*i +: 8];
        end
    end

    assign ramAddr = busy ? st.target : st.memAddr;

    sie_data_ram #(
        .AW(RAM_AW),
        .DW(RAM_DW)
    ) u_ram (
        .mclk(mclk),
        .arst_n(arst_n),
        .addr(ramAddr),
        .we(ramWe),
        .wdata(ramWdata),
        .rdata(ramRdata)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_st = st;
        ramWe = 1'b0;
        ramWdata = wrMerged[7:0];
        if (awvalid && awready)
        begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_st.wHeld = 1'b1;
            next_st.wData = wdata;
            next_st.wStrb = wstrb;
        end
        if (st.bvalid && bready)
        begin
            next_st.bvalid = 1'b0;
        end
        if (wrFire)
        begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wrView[32] ? RESP_OKAY : RESP_SLVERR;
            case (st.awAddr)
                OFS_INSTR:
                begin
                    next_st.instr = wrMerged[15:0];
                    next_st.phase = S_DECODE;
                end
                OFS_ACC: next_st.acc = wrMerged[7:0];
                OFS_FLAGS: next_st.flags = wrMerged[4:0];
                OFS_BANK_POINTER: next_st.bankPointerRegister = wrMerged[3:0];
                OFS_MEM_ADDR: next_st.memAddr = wrMerged[11:0];
                OFS_MEM_DATA: ramWe = st.wStrb[0];
                default: ramWe = 1'b0;
            endcase
        end
        if (arvalid && arready)
        begin
            next_st.rPend = 1'b1;
            next_st.arAddr = araddr;
        end
        if (st.rPend)
        begin
            next_st.rPend = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = rdView[31:0];
            next_st.rresp = rdView[32] ? RESP_OKAY : RESP_SLVERR;
        end
        if (st.rvalid && rready)
        begin
            next_st.rvalid = 1'b0;
        end
        // quarter phases: decode, read, process, write
        case (st.phase)
            S_IDLE:
            begin
            end
            S_DECODE:
            begin
                next_st.isLit = literalMinusAccumulator;
                next_st.destReg = st.instr[9];
                next_st.illegal = !literalMinusAccumulator
                                  && !registerMinusAccumulator;
                next_st.target[7:0] = st.instr[7:0];
                next_st.target[11:8] = st.instr[8]
                    ? st.bankPointerRegister // [RQ8]
                    : st.instr[7] ? ACCESS_BANK_HI : ACCESS_BANK_LO; // [RQ7]
                next_st.phase = next_st.illegal ? S_IDLE : S_READ; // [RQ3][RQ9]
            end
            S_READ:
            begin
                next_st.opA = st.instr[7:0]; // [RQ1]
                next_st.phase = S_PROCESS;
            end
            S_PROCESS:
            begin
                next_st.opA = minuend;
                next_st.result = diff9[7:0]; // [RQ11]
                next_st.pend[FLG_CARRY] = diff9[8]; // [RQ10]
                next_st.pend[FLG_ZERO] = (diff9[7:0] == 8'h00); // [RQ10]
                next_st.pend[FLG_NEGATIVE] = diff9[7]; // [RQ11]
                next_st.pend[FLG_NIBBLE_CARRY] = nib5[4]; // [RQ12]
                next_st.pend[FLG_SIGNED_RANGE] = (minuend[7] ^ st.acc[7])
                    & (diff9[7] ^ minuend[7]); // [RQ12]
                next_st.phase = S_WRITE;
            end
            S_WRITE:
            begin
                next_st.flags = st.pend; // [RQ2]
                if (st.isLit || !st.destReg)
                begin
                    next_st.acc = st.result; // [RQ2] [RQ5]
                end
                else
                begin
                    ramWe = 1'b1; // [RQ6]
                    ramWdata = st.result;
                end
                next_st.phase = S_IDLE;
            end
            default: next_st.phase = S_IDLE;
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '0;
            st.phase <= S_IDLE;
            st.instr <= RST_INSTR;
            st.acc <= RST_ACC;
            st.flags <= RST_FLAGS;
            st.bankPointerRegister <= RST_BANK;
            st.memAddr <= RST_MEM_ADDR;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_lit_operand: // [RQ1]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_PROCESS && st.isLit |=>
        st.result == 8'($past(st.instr[7:0]) - $past(st.acc)))
    else $error("literal difference wrong");
    a_lit_to_acc: // [RQ2]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_WRITE && st.isLit |->
        !ramWe ##1 (st.acc == $past(st.result)
                    && st.flags == $past(st.pend)))
    else $error("literal result not in accumulator");
    a_lit_quarters: // [RQ3]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_DECODE && literalMinusAccumulator |=>
        st.phase == S_READ ##1 st.phase == S_PROCESS
        ##1 st.phase == S_WRITE ##1 st.phase == S_IDLE)
    else $error("literal sequence wrong");
    a_reg_diff: // [RQ4]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_PROCESS && !st.isLit |=>
        st.result == 8'($past(ramRdata) - $past(st.acc)))
    else $error("register difference wrong");
    a_dest_acc: // [RQ5]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_WRITE && !st.isLit && !st.destReg |->
        !ramWe ##1 st.acc == $past(st.result))
    else $error("accumulator destination wrong");
    a_dest_reg: // [RQ6]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_WRITE && !st.isLit && st.destReg |->
        ramWe && ramWdata == st.result && ramAddr == st.target
        ##1 st.acc == $past(st.acc))
    else $error("register destination wrong");
    a_access_bank: // [RQ7]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_READ && !st.isLit && !st.instr[8] |->
        ramAddr == {st.instr[7] ? ACCESS_BANK_HI : ACCESS_BANK_LO,
                    st.instr[7:0]})
    else $error("access bank address wrong");
    a_bank_pointer: // [RQ8]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_READ && !st.isLit && st.instr[8] |->
        ramAddr == {st.bankPointerRegister, st.instr[7:0]})
    else $error("banked address wrong");
    a_reg_quarters: // [RQ9]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_DECODE && registerMinusAccumulator |->
        ##3 st.phase == S_WRITE ##1 !busy)
    else $error("register sequence wrong");
    a_carry_zero: // [RQ10]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_WRITE |=>
        st.flags[FLG_CARRY] == ($past(st.opA) >= $past(st.acc))
        && st.flags[FLG_ZERO] == ($past(st.opA) == $past(st.acc)))
    else $error("carry or zero flag wrong");
    a_borrow_neg: // [RQ11]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_WRITE && st.opA < st.acc |=>
        !st.flags[FLG_CARRY] && !st.flags[FLG_ZERO]
        && st.flags[FLG_NEGATIVE])
    else $error("borrow flags wrong");
    a_signed_nibble: // [RQ12]
    assert property (@(posedge mclk) disable iff (!arst_n)
        st.phase == S_WRITE |=>
        st.flags[FLG_NIBBLE_CARRY]
            == ($past(st.opA[3:0]) >= $past(st.acc[3:0]))
        && st.flags[FLG_SIGNED_RANGE]
            == (($past(st.opA[7]) != $past(st.acc[7]))
                && ($past(st.result[7]) != $past(st.opA[7]))))
    else $error("nibble or signed flag wrong");
endmodule : sie_core

// ==== sie_core_tb_top.sv ====
// sie_core_tb_top.sv: self-checking bench for the subtract execution core
// assumes: sie_pkg and the design files are compiled first; 20 MHz mclk
`timescale 1ns/1ns
module sie_core_tb_top
    import sie_pkg::*;
;
    // ************************************************************
    // clock, reset and bus signals
    // ************************************************************
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [ADDR_W-1:0] awaddr = 8'h00;
    logic [ADDR_W-1:0] araddr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    int mismatches = 0;
    int nCompared = 0;
    int cyc = 0;

    initial forever #25 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    sie_core sie_core_inst (
        .mclk(mclk), .arst_n(arst_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    // ************************************************************
    // reporting
    // ************************************************************
    task wrap_up;
        $display("compared %0d mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task timeout;
        mismatches++;
        $display("[FAIL] handshake expected answer seen none");
        wrap_up();
    endtask : timeout

    // ************************************************************
    // AXI4-Lite master tasks
    // ************************************************************
    // ready is looked at on the falling edge, so it is the value that the
    // next rising edge samples; release happens after that rising edge
    // bready and rready stay high once raised, so calls never toggle them
    task axi_write(input logic [7:0] a, input logic [31:0] d,
                   output logic [1:0] resp);
        int i;
        logic aT, wT, aD, wD, got;
        aD = 1'b0;
        wD = 1'b0;
        got = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100 && !(aD && wD); i++)
        begin
            @(negedge mclk);
            aT = awvalid && (awready === 1'b1);
            wT = wvalid && (wready === 1'b1);
            @(posedge mclk);
            if (aT)
            begin
                awvalid <= 1'b0;
                aD = 1'b1;
            end
            if (wT)
            begin
                wvalid <= 1'b0;
                wD = 1'b1;
            end
        end
        for (i = 0; i < 100 && !got && aD && wD; i++)
        begin
            @(negedge mclk);
            if (bvalid === 1'b1)
            begin
                got = 1'b1;
                resp = bresp;
            end
            @(posedge mclk);
        end
        if (!got)
            timeout();
    endtask : axi_write

    task axi_read(input logic [7:0] a, output logic [31:0] d,
                  output logic [1:0] resp);
        int i;
        logic aD, got;
        aD = 1'b0;
        got = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100 && !aD; i++)
        begin
            @(negedge mclk);
            aD = (arready === 1'b1);
            @(posedge mclk);
        end
        arvalid <= 1'b0;
        for (i = 0; i < 100 && !got && aD; i++)
        begin
            @(negedge mclk);
            if (rvalid === 1'b1)
            begin
                got = 1'b1;
                d = rdata;
                resp = rresp;
            end
            @(posedge mclk);
        end
        if (!got)
            timeout();
    endtask : axi_read

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check("bresp", r, RESP_OKAY);
    endtask : wr

    task rd(input string name, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check("rresp", r, RESP_OKAY);
        check(name, d, e);
    endtask : rd

    task mem_wr(input logic [11:0] a, input logic [7:0] v);
        wr(OFS_MEM_ADDR, {20'h00000, a});
        wr(OFS_MEM_DATA, {24'h000000, v});
    endtask : mem_wr

    task mem_rd(input string name, input logic [11:0] a, input logic [7:0] e);
        wr(OFS_MEM_ADDR, {20'h00000, a});
        rd(name, OFS_MEM_DATA, {24'h000000, e});
    endtask : mem_rd

    // ************************************************************
    // expected result: {negative, overflow, zero, nibble carry, carry, diff}
    // ************************************************************
    function logic [12:0] sub_ref(input logic [7:0] m, input logic [7:0] s);
        logic [7:0] r;
        r = m - s;
        return {r[7], (m[7] != s[7]) && (r[7] != m[7]), r == 8'h00,
                m[3:0] >= s[3:0], m >= s, r};
    endfunction : sub_ref

    // ************************************************************
    // instruction scenarios
    // ************************************************************
    // the read of the accumulator stalls until execution ends
    task exec_and_check(input logic [15:0] ins, input logic [7:0] accExp,
                        input logic [4:0] flgExp);
        int t0;
        wr(OFS_INSTR, {16'h0000, ins});
        t0 = cyc;
        rd("acc", OFS_ACC, {24'h000000, accExp});
        check("cycles", (cyc - t0) <= 8, 1'b1);
        rd("flags", OFS_FLAGS, {27'h0, flgExp});
    endtask : exec_and_check

    task run_lit(input logic [7:0] acc, input logic [7:0] k);
        logic [12:0] e;
        e = sub_ref(k, acc);
        wr(OFS_ACC, {24'h000000, acc});
        exec_and_check({OP_LITERAL, k}, e[7:0], e[12:8]);
    endtask : run_lit

    task run_reg(input logic d, input logic a, input logic [7:0] f,
                 input logic [7:0] acc, input logic [11:0] ma,
                 input logic [7:0] mv);
        logic [12:0] e;
        e = sub_ref(mv, acc);
        mem_wr(ma, mv);
        wr(OFS_ACC, {24'h000000, acc});
        exec_and_check({OP_REGISTER, d, a, f}, d ? acc : e[7:0],
                       e[12:8]);
        mem_rd("reg", ma, d ? e[7:0] : mv);
    endtask : run_reg

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rd("instr reset", OFS_INSTR, 32'h00000000);
        rd("acc reset", OFS_ACC, 32'h00000000);
        rd("flags reset", OFS_FLAGS, 32'h00000000);
        rd("bank reset", OFS_BANK_POINTER, 32'h00000000);
        rd("maddr reset", OFS_MEM_ADDR, 32'h00000000);
        rd("status reset", OFS_STATUS, 32'h00000000);
        axi_read(8'h1c, d, r);
        check("unmapped rresp", r, RESP_SLVERR);
        check("unmapped rdata", d, 32'h00000000);
        axi_write(8'h1c, 32'h000000ff, r);
        check("unmapped bresp", r, RESP_SLVERR);
        wstrb <= 4'he;
        wr(OFS_ACC, 32'h000000aa);
        wstrb <= 4'hf;
        rd("acc unstrobed", OFS_ACC, 32'h00000000);
        wr(OFS_INSTR, 32'h0000ffff);
        rd("illegal status", OFS_STATUS, 32'h00000002);
        rd("illegal acc", OFS_ACC, 32'h00000000);
        run_lit(8'h01, 8'h02);
        rd("illegal cleared", OFS_STATUS, 32'h00000000);
        run_lit(8'h02, 8'h02);
        run_lit(8'h03, 8'h02);
        run_lit(8'hff, 8'h7f);
        run_lit(8'h01, 8'h80);
        run_lit(8'h01, 8'h10);
        run_lit(8'h00, 8'h00);
        run_lit(8'h01, 8'hff);
        wr(OFS_BANK_POINTER, 32'h00000003);
        run_reg(1'b0, 1'b1, 8'h45, 8'h02, 12'h345, 8'h03);
        run_reg(1'b1, 1'b1, 8'h45, 8'h02, 12'h345, 8'h01);
        mem_wr(12'h345, 8'h55);
        run_reg(1'b1, 1'b0, 8'h45, 8'h10, 12'h045, 8'h30);
        mem_rd("bank ignored", 12'h345, 8'h55);
        run_reg(1'b1, 1'b0, 8'hc5, 8'h05, 12'hfc5, 8'h80);
        wrap_up();
    end

endmodule : sie_core_tb_top
